// *** logic/usart_sync_map.svh ***
// Register offsets, field positions and reset values of the serial port
//----------------------------------------------------------------------
// Overview of operation
// RULE_01: Break seen as receive flag, framing error and received byte 00h.
// RULE_02: Wake-on-break watches two data-line transitions, then receives.
// RULE_03: Falling data edge wakes and sets flag; rising edge clears wake.
// RULE_04: Synchronous mode moves characters with no start or stop bits.
// RULE_05: Sync, master, receive-enable and port-enable bits select mode.
// RULE_06: Master drives shift clock; clock pin driver on automatically.
// RULE_07: Master makes exactly one clock per data bit, no extra clocks.
// RULE_08: Transmit data changes on leading edge, stable at trailing edge.
// RULE_09: Polarity bit set idles clock high; clear idles clock low.
// RULE_10: Master transmit drives data pin and clock pin automatically.
// RULE_11: Buffered byte waits for empty shift register, then shifts.
// RULE_12: Master receive releases the data pin driver.
// RULE_13: Single receive clocks one character, then clears itself.
// RULE_14: Continuous receive clocks nonstop; clearing aborts partial char.
// RULE_15: Both set: single clears after first char, continuous goes on.
// RULE_16: Bits sampled on trailing edge; done char sets flag, enters FIFO.
// RULE_17: Data register shows oldest char; flag holds while FIFO not empty.
// RULE_18: Slave takes clock from pin, driver off, one bit per clock.
// RULE_19: Third char with full FIFO sets overrun, keeps both, blocks input.
// RULE_20: Single-mode overrun clears on data read; else by receive/port off.
// RULE_21: Nine-bit mode shifts nine bits; ninth bit of oldest char shown.
// RULE_22: Software reads the ninth bit before the data register.
// RULE_23: Software sets up divisor and mode before writing transmit data.
// RULE_24: Master bit clock derived from divisor and speed-select prescale.
//----------------------------------------------------------------------
`ifndef USART_SYNC_MAP_SVH
`define USART_SYNC_MAP_SVH

// Byte offsets on the register bus
`define OFS_BAUD_CTRL   8'h00
`define OFS_RX_CTRL     8'h04
`define OFS_DIV_LO      8'h08
`define OFS_DIV_HI      8'h0C
`define OFS_TX_BUF      8'h10
`define OFS_TX_CTRL     8'h14
`define OFS_RX_DATA     8'h18
`define OFS_PORT_STAT   8'h1C

// baud_control fields
`define B_RX_IDLE       6
`define B_CLK_POL       4
`define B_WIDE_DIV      3
`define B_WAKE          1
`define B_AUTOBAUD      0
// receive_status_control fields
`define B_PORT_EN       7
`define B_RX_NINE       6
`define B_SINGLE        5
`define B_CONT          4
`define B_ADDR_DET      3
`define B_FRAME_ERR     2
`define B_OVERRUN       1
`define B_RX_NINTH      0
// transmit_status_control fields
`define B_MASTER        7
`define B_TX_NINE       6
`define B_TX_EN         5
`define B_SYNC_SEL      4
`define B_BREAK_SEND    3
`define B_HIGH_SPEED    2
`define B_SHIFT_EMPTY   1
`define B_TX_NINTH      0
// Port status fields
`define B_RX_FLAG       0
`define B_TX_EMPTY      1

// Writable bits and reset values
`define WMASK_BAUD      8'h1B
`define WMASK_RX        8'hF8
`define WMASK_TX        8'hFD
`define RST_BAUD        8'h00
`define RST_RX          8'h00
`define RST_TX          8'h00
`define RST_DIV         16'h0000

// Prescale in system clocks and character lengths
`define PRE_SLOW        7'h40
`define PRE_MID         7'h10
`define PRE_FAST        7'h04
`define BITS_EIGHT      4'h8
`define BITS_NINE       4'h9

`endif

// *** logic/usart_sync_pkg.sv ***
// Types shared by the synchronous serial port
package usart_sync_pkg;
    // Asynchronous receive sequence, Gray coded
    typedef enum logic [1:0] {
        RX_IDLE  = 2'h0,
        RX_START = 2'h1,
        RX_DATA  = 2'h3,
        RX_STOP  = 2'h2
    } async_rx_state_e;
    // FIFO entry: framing error, ninth bit, low byte
    typedef logic [9:0] rx_entry_t;
endpackage : usart_sync_pkg

// *** logic/usart_sync_mode_and_break_rx.sv ***
// Synchronous serial port with break reception and APB registers
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "usart_sync_map.svh"

module usart_sync_mode_and_break_rx
    import usart_sync_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Clock pin
    input  wire logic              clockPinIn,
    output logic                   clockPinOut,
    output logic                   clockPinOeN,
    // Data pin
    input  wire logic              dataPinIn,
    output logic                   dataPinOut,
    output logic                   dataPinOeN
);

//----------------------------------------------------------------------
// Elaboration check
//----------------------------------------------------------------------
if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 8 and 32");
end

//----------------------------------------------------------------------
// Declarations
//----------------------------------------------------------------------
logic [7:0]      baudCtl_ff, rxCtl_ff, txCtl_ff, nxt_rxCtl, nxt_baudCtl;
logic [15:0]     divisor_ff;
logic [7:0]      txBuf_ff, rdData;
logic            txBufFull_ff, tsrBusy_ff, txBit_ff, clkActive_ff;
logic [8:0]      tsr_ff, rsr_ff;
logic [3:0]      txCnt_ff, rxCnt_ff;
logic [6:0]      baseCnt_ff;
logic [15:0]     divCnt_ff;
logic [1:0]      clkSync_ff, dataSync_ff, fifoCnt_ff;
logic            clkPrev_ff, dataPrev_ff, rdIdx_ff, rdPopOk_ff;
logic            overrun_ff, ovrSingle_ff, wakeFlag_ff;
rx_entry_t       fifo_ff [2];
async_rx_state_e rxState_ff, nxt_rxState;

//----------------------------------------------------------------------
// Control fields and mode decode
//----------------------------------------------------------------------
wire clkPol     = baudCtl_ff[`B_CLK_POL];
wire wideDiv    = baudCtl_ff[`B_WIDE_DIV];
wire wakeEn     = baudCtl_ff[`B_WAKE];
wire portEn     = rxCtl_ff[`B_PORT_EN];
wire rxNine     = rxCtl_ff[`B_RX_NINE];
wire singleRx   = rxCtl_ff[`B_SINGLE];
wire contRx     = rxCtl_ff[`B_CONT];
wire masterSel  = txCtl_ff[`B_MASTER];
wire txNine     = txCtl_ff[`B_TX_NINE];
wire transmit_enable       = txCtl_ff[`B_TX_EN];
wire syncSel    = txCtl_ff[`B_SYNC_SEL];
wire highSpeed  = txCtl_ff[`B_HIGH_SPEED];
wire txNinthBit = txCtl_ff[`B_TX_NINTH];
// Mode select; no receive enable means transmit (see RULE_05)
wire syncOn     = portEn & syncSel;
wire txMode     = ~singleRx & ~contRx;
wire masterOn   = syncOn & masterSel;
wire slaveOn    = syncOn & ~masterSel;
wire [3:0] rxBits = rxNine ? `BITS_NINE : `BITS_EIGHT; // see RULE_21
wire [3:0] txBits = txNine ? `BITS_NINE : `BITS_EIGHT;

//----------------------------------------------------------------------
// Pin synchronisers and edge detect
//----------------------------------------------------------------------
// Two stages before any logic; a third flop keeps the prior level
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        clkSync_ff  <= 2'h0;
        dataSync_ff <= 2'h3;
        clkPrev_ff  <= 1'b0;
        dataPrev_ff <= 1'b1;
    end else begin
        clkSync_ff  <= {clkSync_ff[0], clockPinIn};
        dataSync_ff <= {dataSync_ff[0], dataPinIn};
        clkPrev_ff  <= clkSync_ff[1];
        dataPrev_ff <= dataSync_ff[1];
    end
end

wire clkIn    = clkSync_ff[1];
wire dataIn   = dataSync_ff[1];
wire dataFall = dataPrev_ff & ~dataIn;
wire dataRise = ~dataPrev_ff & dataIn;
// Slave edges relative to idle level (see RULE_18)
wire slvLead  = slaveOn & ((clkIn ^ clkPol) & ~(clkPrev_ff ^ clkPol));
wire slvTrail = slaveOn & (~(clkIn ^ clkPol) & (clkPrev_ff ^ clkPol));

//----------------------------------------------------------------------
// Baud generator
//----------------------------------------------------------------------
// Prescale from the speed selects, divisor narrows to a byte when clear
wire [6:0]  presc = wideDiv ? (highSpeed ? `PRE_FAST : `PRE_MID)
                            : (highSpeed ? `PRE_MID : `PRE_SLOW);
wire [15:0] divLimit = wideDiv ? divisor_ff : {8'h00, divisor_ff[7:0]};
wire baseTick = (baseCnt_ff == presc - 7'h01);
wire tick     = baseTick & (divCnt_ff == divLimit); // see RULE_24
wire halfTick = baseTick & (divCnt_ff == (divLimit >> 1));
// Only an async start bit may realign; sync data edges must not
wire restart  = ~syncSel & (rxState_ff == RX_IDLE) & dataFall;
wire reAlign  = restart | ((rxState_ff == RX_START) & halfTick);

// Start bit realigns the divider so samples land mid-bit
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        baseCnt_ff <= 7'h00;
        divCnt_ff  <= 16'h0000;
    end else if (reAlign || baseTick) begin
        baseCnt_ff <= 7'h00;
        divCnt_ff  <= (reAlign || tick) ? 16'h0000 : divCnt_ff + 16'h0001;
    end else begin
        baseCnt_ff <= baseCnt_ff + 7'h01;
    end
end

//----------------------------------------------------------------------
// Master clock generation
//----------------------------------------------------------------------
// Clock runs only while a character is owed (see RULE_07)
wire rxRun     = (singleRx | contRx) & ~overrun_ff;
wire masterRun = masterOn & (txMode ? tsrBusy_ff : rxRun);
wire mstLead   = masterRun & tick & ~clkActive_ff;
wire mstTrail  = masterRun & tick & clkActive_ff;
wire leadEv    = mstLead | slvLead;
wire trailEv   = mstTrail | slvTrail;

// Dropping the run stops the clock at once (see RULE_14)
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) clkActive_ff <= 1'b0;
    else         clkActive_ff <= masterRun & (clkActive_ff ^ tick);
end

//----------------------------------------------------------------------
// Transmit path
//----------------------------------------------------------------------
wire regWr  = psel & penable & pwrite;
wire regRd  = psel & penable & ~pwrite;
wire [7:0] ofs = paddr[7:0];
wire hiZero = ((paddr >> 8) == '0);
wire wrTx   = regWr & hiZero & (ofs == `OFS_TX_BUF);
// Buffer moves on as soon as the shift register is free (see RULE_11)
wire txLoad = txBufFull_ff & ~tsrBusy_ff & transmit_enable & syncOn & txMode;
wire txLast = trailEv & tsrBusy_ff & (txCnt_ff == txBits - 4'h1);

always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        txBuf_ff     <= 8'h00;
        txBufFull_ff <= 1'b0;
    end else begin
        txBuf_ff     <= wrTx ? pwdata[7:0] : txBuf_ff;
        txBufFull_ff <= wrTx | (txBufFull_ff & ~txLoad);
    end
end

// Bits change on the leading edge, hold to the next (see RULE_08)
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        tsr_ff     <= 9'h000;
        txCnt_ff   <= 4'h0;
        tsrBusy_ff <= 1'b0;
        txBit_ff   <= 1'b0;
    end else if (!syncOn) begin
        tsrBusy_ff <= 1'b0;
        txCnt_ff   <= 4'h0;
    end else if (txLoad) begin
        tsr_ff     <= {txNinthBit, txBuf_ff}; // No framing bits, see RULE_04
        txCnt_ff   <= 4'h0;
        tsrBusy_ff <= 1'b1;
    end else begin
        if (leadEv && tsrBusy_ff) begin
            txBit_ff <= tsr_ff[0];
            tsr_ff   <= {1'b0, tsr_ff[8:1]};
        end
        if (trailEv && tsrBusy_ff) begin
            txCnt_ff   <= txCnt_ff + 4'h1;
            tsrBusy_ff <= ~txLast;
        end
    end
end

//----------------------------------------------------------------------
// Receive shift register, synchronous and asynchronous
//----------------------------------------------------------------------
wire syncRxOn  = syncOn & ~txMode & ~overrun_ff &
                 (contRx | (masterSel & singleRx));
wire asyncOn   = portEn & ~syncSel & contRx & ~wakeEn & ~overrun_ff;
wire asyncSamp = (rxState_ff == RX_DATA) & tick;
wire asyncStop = (rxState_ff == RX_STOP) & tick;
wire rxShift   = (syncRxOn & trailEv) | asyncSamp; // see RULE_16
wire rxLastBit = (rxCnt_ff == rxBits - 4'h1);
wire syncDone  = syncRxOn & trailEv & rxLastBit;
wire [8:0] shifted = {dataIn, rsr_ff[8:1]};
wire [8:0] rsrChar = rxNine ? rsr_ff : {1'b0, rsr_ff[8:1]};
wire [8:0] syncChar = rxNine ? shifted : {1'b0, shifted[8:1]};

// Async sequence; stop bit low marks a framing error
always_comb begin
    nxt_rxState = rxState_ff;
    case (rxState_ff)
        RX_IDLE:  if (restart) nxt_rxState = RX_START;
        RX_START: if (halfTick) nxt_rxState = dataIn ? RX_IDLE : RX_DATA;
        RX_DATA:  if (tick && rxLastBit) nxt_rxState = RX_STOP;
        RX_STOP:  if (tick) nxt_rxState = RX_IDLE;
        default:  nxt_rxState = RX_IDLE;
    endcase
    if (!asyncOn) nxt_rxState = RX_IDLE;
end

// Leaving receive mode discards a partial character (see RULE_14)
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        rxState_ff <= RX_IDLE;
        rsr_ff     <= 9'h000;
        rxCnt_ff   <= 4'h0;
    end else begin
        rxState_ff <= nxt_rxState;
        if (rxShift) rsr_ff <= shifted;
        if ((!syncRxOn && !asyncOn) || syncDone || reAlign) rxCnt_ff <= 4'h0;
        else if (rxShift) rxCnt_ff <= rxCnt_ff + 4'h1;
    end
end

//----------------------------------------------------------------------
// Receive FIFO and overrun
//----------------------------------------------------------------------
wire rdRx     = regRd & hiZero & (ofs == `OFS_RX_DATA);
wire pop      = rdRx & rdPopOk_ff; // see RULE_17
wire push     = syncDone | asyncStop;
// Break gives byte 00h with framing error set (see RULE_01)
wire rx_entry_t pushVal = syncDone ? {1'b0, syncChar}
                                   : {~dataIn, rsrChar};
wire pushOk   = push & ((fifoCnt_ff != 2'h2) | pop);
wire ovrSet   = push & ~pushOk; // see RULE_19
wire wrIdx    = rdIdx_ff ^ fifoCnt_ff[0];
wire rx_entry_t top = fifo_ff[rdIdx_ff];
wire rxFlag   = (fifoCnt_ff != 2'h0) | wakeFlag_ff;

for (genvar g = 0; g < 2; g++) begin : g_fifo
    // Storage written only when the entry is free
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)                          fifo_ff[g] <= '0;
        else if (pushOk && wrIdx == 1'(g))    fifo_ff[g] <= pushVal;
    end
end

always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        fifoCnt_ff <= 2'h0;
        rdIdx_ff   <= 1'b0;
    end else if (!portEn) begin
        fifoCnt_ff <= 2'h0;
    end else begin
        fifoCnt_ff <= fifoCnt_ff + {1'b0, pushOk} - {1'b0, pop};
        rdIdx_ff   <= rdIdx_ff ^ pop;
    end
end

// Clear depends on the mode it arose in; a new overrun wins
wire ovrClr = ~portEn | (ovrSingle_ff ? pop : ~contRx); // see RULE_20
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        overrun_ff   <= 1'b0;
        ovrSingle_ff <= 1'b0;
    end else begin
        overrun_ff   <= ovrSet | (overrun_ff & ~ovrClr);
        ovrSingle_ff <= ovrSet ? ~contRx : ovrSingle_ff;
    end
end

// Wake on falling data edge, read clears, set wins (see RULE_03)
wire wakeWatch = wakeEn & portEn & ~syncSel;
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) wakeFlag_ff <= 1'b0;
    else wakeFlag_ff <= (wakeWatch & dataFall) | (wakeFlag_ff & ~rdRx);
end

//----------------------------------------------------------------------
// Register writes and hardware updates
//----------------------------------------------------------------------
wire wrBaud = regWr & hiZero & (ofs == `OFS_BAUD_CTRL);
wire wrRxC  = regWr & hiZero & (ofs == `OFS_RX_CTRL);
wire wrTxC  = regWr & hiZero & (ofs == `OFS_TX_CTRL);
wire wrLo   = regWr & hiZero & (ofs == `OFS_DIV_LO);
wire wrHi   = regWr & hiZero & (ofs == `OFS_DIV_HI);

always_comb begin
    nxt_baudCtl = wrBaud ? (pwdata[7:0] & `WMASK_BAUD) : baudCtl_ff;
    // Break ends on rising data edge (see RULE_02)
    if (!wrBaud && wakeWatch && dataRise) nxt_baudCtl[`B_WAKE] = 1'b0;
    nxt_rxCtl = wrRxC ? (pwdata[7:0] & `WMASK_RX) : rxCtl_ff;
    // One character done ends single receive (see RULE_13, RULE_15)
    if (!wrRxC && syncDone && masterSel) nxt_rxCtl[`B_SINGLE] = 1'b0;
end

always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        baudCtl_ff <= `RST_BAUD;
        rxCtl_ff   <= `RST_RX;
        txCtl_ff   <= `RST_TX;
        divisor_ff <= `RST_DIV;
    end else begin
        baudCtl_ff <= nxt_baudCtl;
        rxCtl_ff   <= nxt_rxCtl;
        if (wrTxC) txCtl_ff <= pwdata[7:0] & `WMASK_TX;
        if (wrLo)  divisor_ff[7:0]  <= pwdata[7:0];
        if (wrHi)  divisor_ff[15:8] <= pwdata[7:0];
    end
end

//----------------------------------------------------------------------
// Register reads
//----------------------------------------------------------------------
// Status bits merged over stored control bits
wire [7:0] baudRd = baudCtl_ff |
                    {1'b0, rxState_ff == RX_IDLE, 6'h00};
wire [7:0] rxRd   = rxCtl_ff |
                    {5'h00, top[9], overrun_ff, top[8]}; // see RULE_21
wire [7:0] txRd   = txCtl_ff | {6'h00, ~tsrBusy_ff, 1'b0};
wire [7:0] statRd = {6'h00, ~txBufFull_ff, rxFlag};
wire       hit    = hiZero & (ofs[1:0] == 2'h0) & (ofs <= `OFS_PORT_STAT);

always_comb begin
    case (ofs)
        `OFS_BAUD_CTRL: rdData = baudRd;
        `OFS_RX_CTRL:   rdData = rxRd;
        `OFS_DIV_LO:    rdData = divisor_ff[7:0];
        `OFS_DIV_HI:    rdData = divisor_ff[15:8];
        `OFS_TX_CTRL:   rdData = txRd;
        `OFS_RX_DATA:   rdData = top[7:0];
        `OFS_PORT_STAT: rdData = statRd;
        default:        rdData = 8'h00;
    endcase
    if (!hiZero) rdData = 8'h00;
end

// Data captured in setup; pop allowed only for what was shown
always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
        prdata     <= 32'h0000_0000;
        rdPopOk_ff <= 1'b0;
    end else if (psel && !penable && !pwrite) begin
        prdata     <= {24'h000000, rdData};
        rdPopOk_ff <= (fifoCnt_ff != 2'h0);
    end
end

assign pready  = 1'b1;
assign pslverr = psel & penable & ~hit;

//----------------------------------------------------------------------
// Pin drivers, enables active low
//----------------------------------------------------------------------
assign clockPinOut = clkPol ^ clkActive_ff;      // see RULE_09
assign clockPinOeN = ~masterOn;                  // see RULE_06
assign dataPinOut  = txBit_ff;
assign dataPinOeN  = ~(syncOn & txMode);         // see RULE_10

//----------------------------------------------------------------------
// Assertions
//----------------------------------------------------------------------
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!resetn);

property p_break_seen;
    (asyncStop && rsrChar == 9'h000 && !dataIn && fifoCnt_ff == 2'h0)
        |=> (rxFlag && top[9] && top[7:0] == 8'h00);
endproperty
a_break_seen: assert property (p_break_seen) // see RULE_01
    else $error("break not reported");

property p_wake_clear;
    (wakeWatch && dataRise && !wrBaud) |=> !wakeEn;
endproperty
a_wake_clear: assert property (p_wake_clear) // see RULE_03
    else $error("wake enable not cleared");

property p_idle_level;
    (masterOn && !masterRun) |=> (clockPinOut == clkPol);
endproperty
a_idle_level: assert property (p_idle_level) // see RULE_14
    else $error("clock not idle after stop");

property p_single_end;
    (syncDone && masterSel && !wrRxC) |=> !singleRx;
endproperty
a_single_end: assert property (p_single_end) // see RULE_13
    else $error("single receive not cleared");

property p_overrun;
    (push && fifoCnt_ff == 2'h2 && !pop)
        |=> (overrun_ff && fifoCnt_ff == 2'h2);
endproperty
a_overrun: assert property (p_overrun) // see RULE_19
    else $error("overrun not flagged");

property p_tx_load;
    txLoad |=> (tsrBusy_ff && tsr_ff[7:0] == $past(txBuf_ff));
endproperty
a_tx_load: assert property (p_tx_load) // see RULE_11
    else $error("transmit buffer not moved");

property p_rx_release;
    (masterOn && !txMode) |-> dataPinOeN;
endproperty
a_rx_release: assert property (p_rx_release) // see RULE_12
    else $error("data pin driven in receive");

property p_tx_stable;
    (tsrBusy_ff && !leadEv && !txLoad) |=> $stable(dataPinOut);
endproperty
a_tx_stable: assert property (p_tx_stable) // see RULE_08
    else $error("data changed off leading edge");

endmodule : usart_sync_mode_and_break_rx
`default_nettype wire

// *** testbench/sync_partner.sv ***
// Behavioural far-side slave device for the synchronous serial port
`timescale 1ns/100ps
`default_nettype none

module sync_partner (
    // Shared lines
    input  wire logic       ckLine,
    input  wire logic       dtLine,
    // Set-up from the bench
    input  wire logic       polarity,
    input  wire logic       clear,
    input  wire logic [8:0] sendWord,
    // Observations
    output logic            dtOut,
    output logic [8:0]      seenBits,
    output logic [5:0]      edgeCount
);
    //------------------------------------------------------------------
    // Shifting on the clock line
    //------------------------------------------------------------------
    int unsigned bitIdx;

    // Leading edge moves our bit, trailing edge captures the other one
    always @(ckLine or posedge clear) begin
        if (clear) begin
            bitIdx    = 0;
            edgeCount = '0;
            seenBits  = '0;
            dtOut     = ~sendWord[0]; // Never the value about to be sent
        end else if (ckLine !== polarity) begin
            dtOut  = sendWord[bitIdx % 9];
            bitIdx = bitIdx + 1;
        end else begin
            seenBits  = {dtLine, seenBits[8:1]};
            edgeCount = edgeCount + 6'h01;
        end
    end
endmodule : sync_partner
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the synchronous serial port
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    //------------------------------------------------------------------
    // Stimulus, wiring and bookkeeping
    //------------------------------------------------------------------
    logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdVal;
    logic        clockPinOut, clockPinOeN, dataPinOut, dataPinOeN;
    logic        partnerDt, pol, pClr, err;
    logic [8:0]  sendWord, seenBits;
    logic [5:0]  edgeCount;
    wire         ckLine;
    wire         dtLine;
    int          fail_count, compares, cycles;

    // Released lines: clock rests at idle, data comes from the partner
    assign ckLine = clockPinOeN ? pol : clockPinOut;
    assign dtLine = dataPinOeN ? partnerDt : dataPinOut;

    usart_sync_mode_and_break_rx uut (.ref_clk(ref_clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clockPinIn(ckLine), .clockPinOut(clockPinOut),
        .clockPinOeN(clockPinOeN), .dataPinIn(dtLine),
        .dataPinOut(dataPinOut), .dataPinOeN(dataPinOeN));

    sync_partner far (.ckLine(ckLine), .dtLine(dtLine), .polarity(pol),
        .clear(pClr), .sendWord(sendWord), .dtOut(partnerDt),
        .seenBits(seenBits), .edgeCount(edgeCount));

    // Clock source
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard, far above the well under two thousand cycles the run needs
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            conclude();
        end
    end

    //------------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %0h, seen %0h", name, exp, got);
        end
    endtask : check

    // One APB transfer; held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdVal = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic waitEdges(input logic [5:0] n);
        for (int i = 0; i < 4000 && edgeCount !== n; i++) @(posedge ref_clk);
    endtask : waitEdges

    // Partner gets a new word and forgets earlier edges
    task automatic restartPartner(input logic [8:0] w);
        sendWord <= w;
        pClr     <= 1'b1;
        @(posedge ref_clk);
        pClr     <= 1'b0;
    endtask : restartPartner

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic tRegs();
        apb(1'b0, 8'h04, 32'h0);
        check("rxCtrlReset", 32'h0, rdVal);
        apb(1'b0, 8'h14, 32'h0);
        check("txCtrlReset", 32'h2, rdVal);
        check("clkOeOff", 32'h1, {31'h0, clockPinOeN});
        apb(1'b0, 8'h20, 32'h0);
        check("unmappedErr", 32'h1, {31'h0, err});
    endtask : tRegs

    // Two bytes back to back; the second waits for the shifter
    task automatic tTx(input logic p);
        apb(1'b1, 8'h00, {27'h0, p, 4'h8});
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h04, 32'h80);
        apb(1'b1, 8'h14, 32'hB4);
        pol <= p;
        restartPartner(9'h000);
        apb(1'b1, 8'h10, 32'hA5);
        apb(1'b1, 8'h10, 32'h3C);
        waitEdges(6'h08);
        check("txFirst", 32'hA5, {24'h0, seenBits[8:1]});
        waitEdges(6'h10);
        check("txSecond", 32'h3C, {24'h0, seenBits[8:1]});
        repeat (60) @(posedge ref_clk);
        check("txClocks", 32'h10, {26'h0, edgeCount});
        check("txIdle", {31'h0, p}, {31'h0, ckLine});
        check("txOe", 32'h0, {30'h0, clockPinOeN, dataPinOeN});
    endtask : tTx

    // Single receive of an eight or nine bit character
    task automatic tRx(input logic [8:0] w, input logic nine);
        apb(1'b1, 8'h14, 32'h94);
        restartPartner(w);
        apb(1'b1, 8'h04, {24'h0, 1'b1, nine, 6'h20});
        waitEdges(6'h04);
        check("rxDataOe", 32'h1, {31'h0, dataPinOeN});
        repeat (200) @(posedge ref_clk);
        check("rxClocks", {28'h0, 1'b1, 2'h0, nine}, {26'h0, edgeCount});
        apb(1'b0, 8'h04, 32'h0);
        check("rxCtrl", {24'h0, 1'b1, nine, 5'h0, w[8] & nine}, rdVal);
        apb(1'b0, 8'h18, 32'h0);
        check("rxData", {24'h0, w[7:0]}, rdVal);
        apb(1'b0, 8'h1C, 32'h0);
        check("rxFlag", 32'h0, {31'h0, rdVal[0]});
    endtask : tRx

    // Three characters unread; the third is refused
    task automatic tOverrun();
        for (int k = 1; k <= 3; k++) begin
            restartPartner({1'b0, 4'(k), 4'(k)});
            apb(1'b1, 8'h04, 32'hA0);
            repeat (200) @(posedge ref_clk);
        end
        apb(1'b0, 8'h04, 32'h0);
        check("ovrSet", 32'h1, {31'h0, rdVal[1]});
        apb(1'b0, 8'h18, 32'h0);
        check("ovrFirst", 32'h11, rdVal);
        apb(1'b0, 8'h04, 32'h0);
        check("ovrClear", 32'h0, {31'h0, rdVal[1]});
        apb(1'b0, 8'h18, 32'h0);
        check("ovrSecond", 32'h22, rdVal);
    endtask : tOverrun

    task automatic conclude();
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    // Main sequence
    initial begin
        {resetn, psel, penable, pwrite, pol} = '0;
        pClr <= 1'b1; // Partner data line known from the start
        {paddr, pwdata, sendWord} = '0;
        {fail_count, compares, cycles} = '0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        pClr   <= 1'b0;
        tRegs();
        tTx(1'b0);
        tTx(1'b1);
        tRx(9'h0C3, 1'b0);
        tRx(9'h15A, 1'b1);
        tOverrun();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
